// [fixed_point_load_execution.sv]
// Execution datapath for fixed-point load operations with 16 general registers.
// Assumes a sequencer pulses start with opcode, fields, operand and address stable,
// and the storage bus holds the fetched doubleword while busy.
// Summary of operation
// [RULE_01] Loads write the second operand to the first register; source stays untouched.
// [RULE_02] Register copy skips specification test, writes first register, then end op.
// [RULE_03] Word load tests specification first; a fault forces end op, no write.
// [RULE_04] Word load takes right word when address bit 21 is one, else left.
// [RULE_05] Halfword load sign-extends sixteen bits to thirty-two before writing.
// [RULE_06] Halfword load tests specification first; a fault forces end op, suppresses.
// [RULE_07] Sign mask built in three shift cycles ending at FFFF0000.
// [RULE_08] Halfword load takes bus bits 0-31 or 32-63 by address bit 21.
// [RULE_09] Address bit 22 picks halfword; one injected at bit 47 if sign zero.
// [RULE_10] Mask plus operand gives word written to register in bits 8-11, then end op.
// [RULE_11] Test-and-copy passes operand through adder, sets zero flag, writes register.
// [RULE_12] Condition code zero if flag set, else one for minus, two for plus.
// [RULE_13] Same register in both fields still evaluates zero and sign.
// [RULE_14] Condition code changes only for test-and-copy.
`timescale 1ns/1ps
module fixed_point_load_execution
    import load_exec_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        start,
    input  wire logic [7:0]  opcode,
    input  wire logic [3:0]  first_register_field,
    input  wire logic [3:0]  second_register_field,
    input  wire logic [31:0] operand_address,
    input  wire logic        spec_check,
    input  wire logic [63:0] storage_data_out_bus,
    output logic             busy,
    output logic             end_op,
    output logic             spec_interrupt,
    output logic [1:0]       condition_code,
    output logic             zero_result,
    output logic [31:0]      adder_output_latch,
    output logic [31:0]      reg_read_data
);
    exec_state_type state;
    exec_state_type next_state;
    logic [7:0]  op;
    logic [7:0]  next_op;
    logic [3:0]  dest;
    logic [3:0]  next_dest;
    logic [31:0] addr;
    logic [31:0] next_addr;
    logic [31:0] operand;
    logic [31:0] next_operand;
    logic [31:0] mask;
    logic [31:0] next_mask;
    logic [1:0]  steps;
    logic [1:0]  next_steps;
    logic [31:0] next_adder_output_latch;
    logic        next_busy;
    logic        next_end_op;
    logic        next_spec_interrupt;
    logic [1:0]  next_condition_code;
    logic        next_zero_result;
    logic [31:0] next_reg_read_data;
    logic [31:0] local_store_registers [0:15];
    logic        wr_en;
    logic [31:0] wr_data;
    logic [31:0] adder_input_a;
    logic [31:0] adder_input_b;
    logic [15:0] half;
    logic [31:0] adder_sum;
    logic [31:0] selected_word;
    logic [31:0] source_word;
    logic        sum_is_zero;
    logic [1:0]  cc_eval;
    logic        op_is_half;
    logic        op_is_test;
    logic        mask_done;

    // Read port for the second operand; also feeds the observation port
    always_comb begin
        source_word = local_store_registers[second_register_field]; // RULE_01
    end

    // Decode of the operation held for the running instruction
    always_comb begin
        op_is_half = 1'b0;
        op_is_test = 1'b0;
        if (op == `OP_LOAD_HALF) begin
            op_is_half = 1'b1;
        end
        if (op == `OP_TEST_COPY) begin
            op_is_test = 1'b1;
        end
    end

    // Mask build finishes after the third shift
    always_comb begin
        mask_done = 1'b0;
        if (steps == `MASK_STEPS) begin
            mask_done = 1'b1; // RULE_07
        end
    end

    // Word of the doubleword picked by address bit 21
    always_comb begin
        if (addr[31 - `ADDR_WORD_BIT]) begin
            selected_word = storage_data_out_bus[31:0]; // RULE_04 RULE_08
        end else begin
            selected_word = storage_data_out_bus[63:32]; // RULE_04 RULE_08
        end
    end

    // Shared parallel adder; inputs chosen by state and operation
    always_comb begin
        half = 16'h0000;
        adder_input_a = 32'h00000000;
        adder_input_b = 32'h00000000;
        if (state == st_add) begin
            if (op_is_half) begin
                if (addr[31 - `ADDR_HALF_BIT]) begin
                    half = operand[15:0]; // RULE_09
                end else begin
                    half = operand[31:16]; // RULE_09
                end
                // Sign zero injects a one at bit 47; its carry clears the mask
                adder_input_a = {15'h0000, ~half[15], half}; // RULE_09
                adder_input_b = mask; // RULE_10
            end else begin
                adder_input_a = operand; // RULE_11
            end
        end
        adder_sum = adder_input_a + adder_input_b; // RULE_05
    end

    // All-zero detect on the adder result
    always_comb begin
        sum_is_zero = 1'b0;
        if (adder_sum == 32'h00000000) begin
            sum_is_zero = 1'b1; // RULE_11 RULE_13
        end
    end

    // Condition code from the zero flag and the operand sign
    always_comb begin
        if (zero_result) begin
            cc_eval = `CC_ZERO; // RULE_12
        end else if (operand[31]) begin
            cc_eval = `CC_MINUS; // RULE_12
        end else begin
            cc_eval = `CC_PLUS; // RULE_12
        end
    end

    always_comb begin
        next_state = state;
        next_op = op;
        next_dest = dest;
        next_addr = addr;
        next_operand = operand;
        next_mask = mask;
        next_steps = steps;
        next_adder_output_latch = adder_output_latch;
        next_busy = busy;
        next_end_op = 1'b0;
        next_spec_interrupt = 1'b0;
        next_condition_code = condition_code;
        next_zero_result = zero_result;
        next_reg_read_data = source_word;
        wr_en = 1'b0;
        wr_data = operand;
        unique case (state)
            st_idle: begin
                if (start) begin
                    next_op = opcode;
                    next_dest = first_register_field;
                    next_addr = operand_address;
                    // Second operand read only; source register written only when both fields name it
                    next_operand = source_word; // RULE_01
                    next_busy = 1'b1;
                    if (opcode == `OP_COPY_REG) begin
                        next_state = st_write; // RULE_02
                    end else if (opcode == `OP_TEST_COPY) begin
                        next_state = st_add;
                    end else if (opcode == `OP_LOAD_WORD || opcode == `OP_LOAD_HALF) begin
                        if (spec_check) begin
                            next_spec_interrupt = 1'b1; // RULE_03
                            next_state = st_end_op; // RULE_06
                        end else if (opcode == `OP_LOAD_HALF) begin
                            next_mask = `MASK_INIT << 4; // RULE_07
                            next_steps = 2'h1;
                            next_state = st_mask;
                        end else begin
                            next_state = st_select;
                        end
                    end else begin
                        next_state = st_end_op;
                    end
                end
            end
            st_mask: begin
                // Mask progresses FFFFFF00, FFFFF000, FFFF0000
                if (mask_done) begin
                    next_state = st_select;
                end else begin
                    next_mask = mask << 4; // RULE_07
                    next_steps = steps + 2'h1;
                end
            end
            st_select: begin
                next_operand = selected_word; // RULE_04 RULE_08
                if (op_is_half) begin
                    next_state = st_add;
                end else begin
                    next_state = st_write;
                end
            end
            st_add: begin
                next_adder_output_latch = adder_sum; // RULE_10 RULE_11
                if (op_is_half) begin
                    next_operand = adder_sum; // RULE_05 RULE_10
                end else begin
                    next_zero_result = sum_is_zero; // RULE_11 RULE_13
                end
                next_state = st_write;
            end
            st_write: begin
                wr_en = 1'b1; // RULE_01 RULE_10
                if (op_is_test) begin
                    // Only test-and-copy touches the condition code
                    next_condition_code = cc_eval; // RULE_12 RULE_14
                end
                next_state = st_end_op;
            end
            st_end_op: begin
                next_end_op = 1'b1;
                next_busy = 1'b0;
                next_state = st_idle;
            end
            default: begin
                next_state = st_idle;
                next_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= st_idle;
            op <= 8'h00;
            dest <= 4'h0;
            addr <= 32'h00000000;
            operand <= 32'h00000000;
            mask <= 32'h00000000;
            steps <= 2'h0;
            adder_output_latch <= 32'h00000000;
            busy <= 1'b0;
            end_op <= 1'b0;
            spec_interrupt <= 1'b0;
            condition_code <= 2'h0;
            zero_result <= 1'b0;
            reg_read_data <= 32'h00000000;
        end else begin
            state <= next_state;
            op <= next_op;
            dest <= next_dest;
            addr <= next_addr;
            operand <= next_operand;
            mask <= next_mask;
            steps <= next_steps;
            adder_output_latch <= next_adder_output_latch;
            busy <= next_busy;
            end_op <= next_end_op;
            spec_interrupt <= next_spec_interrupt;
            condition_code <= next_condition_code;
            zero_result <= next_zero_result;
            reg_read_data <= next_reg_read_data;
        end
    end

    // Register file has no reset; contents start undefined
    always_ff @(posedge clk) begin
        if (wr_en) begin
            local_store_registers[dest] <= wr_data; // RULE_01
        end
    end
endmodule : fixed_point_load_execution

// [load_exec_defs.svh]
// Constants for the fixed-point load execution datapath.
// Included by the package, the checker and the bench; definitions only.
`ifndef LOAD_EXEC_DEFS_SVH
`define LOAD_EXEC_DEFS_SVH
`define OP_COPY_REG      8'h18
`define OP_LOAD_WORD     8'h58
`define OP_LOAD_HALF     8'h48
`define OP_TEST_COPY     8'h12
`define MASK_INIT        32'hFFFFFFF0
`define MASK_STEPS       2'h3
`define CC_ZERO          2'h0
`define CC_MINUS         2'h1
`define CC_PLUS          2'h2
`define ADDR_WORD_BIT    21
`define ADDR_HALF_BIT    22
`endif

// [load_exec_pkg.sv]
// Types for the fixed-point load execution datapath.
// Assumes the defs header sits in the same folder.
`include "load_exec_defs.svh"
package load_exec_pkg;
    typedef enum logic [2:0] {
        st_idle    = 3'b000,
        st_mask    = 3'b001,
        st_select  = 3'b010,
        st_add     = 3'b011,
        st_write   = 3'b100,
        st_end_op  = 3'b101
    } exec_state_type;
endpackage : load_exec_pkg

// [storage_bus_model.sv]
// Storage data bus model for the load datapath.
// Drives the fetched doubleword while the datapath is busy.
`timescale 1ns/1ps
module storage_bus_model (
    input  wire logic        busy,
    input  wire logic [63:0] fetched,
    output logic      [63:0] bus
);
    // Released bus shows the inverse, never the old word
    assign bus = busy ? fetched : ~fetched;
endmodule : storage_bus_model

// [load_exec_sva.sv]
// Checker for the load datapath: timing, flags, sign extension.
// Bound to the datapath top; sees its ports only.
`timescale 1ns/1ps
`include "load_exec_defs.svh"
module load_exec_sva (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        start,
    input wire logic        busy,
    input wire logic        end_op,
    input wire logic        spec_interrupt,
    input wire logic        spec_check,
    input wire logic [7:0]  opcode,
    input wire logic [1:0]  condition_code,
    input wire logic        zero_result,
    input wire logic [31:0] adder_output_latch
);
    logic [7:0] last_op;
    logic [7:0] next_last_op;
    logic       take;
    logic       fault;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    assign take = start && !busy;
    assign fault = take && spec_check && (opcode == `OP_LOAD_WORD || opcode == `OP_LOAD_HALF);
    always_comb begin
        next_last_op = take ? (fault ? 8'h00 : opcode) : last_op;
        if (reset) begin
            next_last_op = 8'h00;
        end
    end
    always_ff @(posedge clk) begin
        last_op <= next_last_op;
    end
    property p_copy; take && opcode == `OP_COPY_REG |-> ##3 end_op; endproperty
    a_copy: assert property (p_copy) else $error("copy timing");
    property p_word; take && opcode == `OP_LOAD_WORD && !spec_check |-> ##4 end_op; endproperty
    a_word: assert property (p_word) else $error("word timing");
    property p_half; take && opcode == `OP_LOAD_HALF && !spec_check
        |-> ##1 !end_op [*7] ##1 end_op; endproperty
    a_half: assert property (p_half) else $error("half timing");
    property p_fault; fault |=> spec_interrupt && busy ##1 end_op && !busy; endproperty
    a_fault: assert property (p_fault) else $error("spec fault");
    property p_hold; busy && last_op != `OP_TEST_COPY
        |=> $stable(condition_code) && $stable(zero_result); endproperty
    a_hold: assert property (p_hold) else $error("cc changed");
    property p_cc; end_op && last_op == `OP_TEST_COPY |-> condition_code == (zero_result
        ? `CC_ZERO : adder_output_latch[31] ? `CC_MINUS : `CC_PLUS); endproperty
    a_cc: assert property (p_cc) else $error("cc value");
    property p_zero; end_op && last_op == `OP_TEST_COPY
        |-> zero_result == (adder_output_latch == 32'h0); endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    property p_sext; end_op && last_op == `OP_LOAD_HALF
        |-> adder_output_latch[31:16] == {16{adder_output_latch[15]}}; endproperty
    a_sext: assert property (p_sext) else $error("sign ext");
endmodule : load_exec_sva
bind fixed_point_load_execution load_exec_sva u_load_exec_sva (.clk, .reset, .start, .busy,
    .end_op, .spec_interrupt, .spec_check, .opcode, .condition_code, .zero_result,
    .adder_output_latch);

// [fixed_point_load_execution_test.sv]
// Self-checking bench for the fixed-point load datapath.
// Needs the storage bus model and the bound checker.
`timescale 1ns/1ps
`include "load_exec_defs.svh"
module fixed_point_load_execution_test;
    logic        clk = 1'b0, reset = 1'b1, start = 1'b0, spec = 1'b0, saw;
    logic        busy, end_op, spec_int, zero;
    logic [1:0]  cc;
    logic [3:0]  r1 = 4'h0, r2 = 4'h0;
    logic [7:0]  op = 8'h00;
    logic [31:0] addr = 32'h0, aol, rrd, v, s = 32'h146A;
    logic [31:0] tv [4] = '{32'h0, 32'h8000_0000, 32'h7FFF_FFFF, 32'h1};
    logic [63:0] dw = 64'h0, bus;
    int          err_total = 0, samples_checked = 0;
    always #4 clk = ~clk;
    storage_bus_model u_storage_bus_model (.busy(busy), .fetched(dw), .bus(bus));
    fixed_point_load_execution u_fixed_point_load_execution (.clk(clk), .reset(reset),
        .start(start), .opcode(op), .first_register_field(r1), .second_register_field(r2),
        .operand_address(addr), .spec_check(spec), .storage_data_out_bus(bus), .busy(busy),
        .end_op(end_op), .spec_interrupt(spec_int), .condition_code(cc), .zero_result(zero),
        .adder_output_latch(aol), .reg_read_data(rrd));
    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : rnd
    function automatic logic [31:0] half(logic [63:0] d, logic [31:0] a);
        logic [31:0] w;
        logic [15:0] h;
        w = a[10] ? d[31:0] : d[63:32];
        h = a[9] ? w[15:0] : w[31:16];
        return {{16{h[15]}}, h};
    endfunction : half
    function automatic logic [1:0] ccx(logic [31:0] x);
        return x == 32'h0 ? `CC_ZERO : x[31] ? `CC_MINUS : `CC_PLUS;
    endfunction : ccx
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic run(logic [7:0] o, logic [3:0] a, logic [3:0] b, logic [31:0] d, logic p);
        int n;
        @(negedge clk);
        {op, r1, r2, addr, spec} = {o, a, b, d, p};
        start = 1'b1;
        saw = 1'b0;
        @(negedge clk);
        start = 1'b0;
        for (n = 0; n < 20 && end_op !== 1'b1; n++) begin
            saw |= spec_int === 1'b1;
            @(negedge clk);
        end
        chk("end op", 32'h1, 32'(end_op));
        chk("busy at end op", 32'h0, 32'(busy));
    endtask : run
    task automatic rd(logic [3:0] r, logic [31:0] e);
        @(negedge clk);
        r2 = r;
        @(negedge clk);
        chk("register", e, rrd);
    endtask : rd
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        #100000;
        err_total++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        for (int i = 0; i < 8; i++) begin
            dw = {rnd(), rnd()};
            v = rnd();
            run(`OP_LOAD_WORD, i[3:0], 4'h0, v, 1'b0);
            rd(i[3:0], v[10] ? dw[31:0] : dw[63:32]);
            chk("cc kept", 32'h0, 32'(cc));
        end
        $display("word loads done");
        for (int i = 0; i < 8; i++) begin
            dw = {rnd(), rnd()};
            if (i == 0) dw[63:48] = 16'h8000;
            v = {21'h0, i[1:0], 9'h0};
            run(`OP_LOAD_HALF, 4'h8, 4'h0, v, 1'b0);
            rd(4'h8, half(dw, v));
            chk("adder latch", half(dw, v), aol);
        end
        $display("halfword loads done");
        foreach (tv[j]) begin
            dw = {tv[j], ~tv[j]};
            run(`OP_LOAD_WORD, 4'hC, 4'h0, 32'h0, 1'b0);
            run(`OP_TEST_COPY, 4'hF, 4'hC, 32'h0, 1'b0);
            chk("cc", 32'(ccx(tv[j])), 32'(cc));
            chk("zero flag", 32'(tv[j] == 32'h0), 32'(zero));
            rd(4'hF, tv[j]);
            run(`OP_TEST_COPY, 4'hC, 4'hC, 32'h0, 1'b0);
            rd(4'hC, tv[j]);
            run(`OP_COPY_REG, 4'h3, 4'hC, 32'h0, 1'b0);
            chk("cc after copy", 32'(ccx(tv[j])), 32'(cc));
            rd(4'h3, tv[j]);
        end
        $display("test and copy done");
        for (int k = 0; k < 2; k++) begin
            dw = {rnd(), rnd()};
            run(k ? `OP_LOAD_HALF : `OP_LOAD_WORD, 4'hF, 4'h0, 32'h0, 1'b1);
            chk("spec interrupt", 32'h1, 32'(saw));
            rd(4'hF, tv[3]);
        end
        run(`OP_COPY_REG, 4'h5, 4'hF, 32'h0, 1'b1);
        chk("copy ignores spec", 32'h0, 32'(saw));
        rd(4'h5, tv[3]);
        run(8'h00, 4'h5, 4'h0, 32'h0, 1'b0);
        rd(4'h5, tv[3]);
        $display("spec faults done");
        complete_run();
    end
endmodule : fixed_point_load_execution_test
